// file: dv/auto_scan_channel_select_chk.sv
// concurrent checks on the scan selector's bus and conversion request ports
// assumes one clock domain and binding onto auto_scan_channel_select
`timescale 1ns/100ps
module scan_sel_chk
    import scan_sel_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        scan_tick,
    input  wire logic        period_restart,
    input  wire logic        conv_valid,
    input  wire conv_req_t   conv_req
);
    logic       acc;
    logic       wr_per;
    logic [4:0] ch;
    logic [4:0] last_ch_ff;
    assign acc    = hsel && htrans[1] && hready && ce;
    assign wr_per = acc && hwrite && haddr == 32'h0000_00C8;
    assign ch     = conv_req.channel;
    // cleared at every scan_tick or period_restart pulse so a new scan may open with cells again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) last_ch_ff <= CH_NONE;
        else if (period_restart || scan_tick) last_ch_ff <= CH_NONE;
        else if (conv_valid) last_ch_ff <= ch;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_chan_s;
        acc && !hwrite && haddr == 32'h0000_00CC;
    endsequence
    sequence first_cell_s;
        conv_valid && ch <= CH_CELL_LAST && ch != last_ch_ff;
    endsequence
    restart_after_wr_a: assert property (wr_per |-> ##2 period_restart)
        else $error("no restart pulse after period write");
    restart_cause_a: assert property (period_restart |-> $past(wr_per, 2))
        else $error("restart pulse without period write");
    rsvd_zero_a: assert property (rd_chan_s |=> (hrdata & 32'h0000_007B) == 32'h0)
        else $error("reserved channel bits read nonzero");
    first_settle_a: assert property (first_cell_s |-> conv_req.timing == TM_CELL_SETTLE)
        else $error("new cell sampled without settling period");
    cell_timing_a: assert property (conv_valid && ch <= CH_CELL_LAST
        |-> conv_req.timing inside {TM_CELL_SETTLE, TM_ANALOG_AVG}) else $error("cell timing");
    aux_timing_a: assert property (conv_valid && ch inside {[CH_AUX_FIRST:CH_AUX_LAST]}
        |-> conv_req.timing inside {TM_AUX_SETTLE, TM_DIGITAL_AVG}) else $error("aux timing");
    misc_timing_a: assert property (conv_valid && ch >= CH_DTEMP
        |-> conv_req.timing == (ch == CH_DTEMP ? TM_DIGITAL_AVG : TM_ANALOG_AVG))
        else $error("temperature or reference timing");
    ref_order_a: assert property (conv_valid && ch == CH_REF_GND
        && last_ch_ff != CH_REF_GND |-> last_ch_ff == CH_REF) else $error("ground before ref");
    group_order_a: assert property (conv_valid && ch <= CH_AUX_LAST |-> last_ch_ff == CH_NONE
        || last_ch_ff <= (ch[4] ? CH_AUX_LAST : CH_CELL_LAST)) else $error("group order");
endmodule // scan_sel_chk

bind auto_scan_channel_select scan_sel_chk i_chk (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .scan_tick(scan_tick), .period_restart(period_restart),
    .conv_valid(conv_valid), .conv_req(conv_req)
);

// file: dv/tb_auto_scan_channel_select.sv
// self-checking bench: AHB-Lite register tasks plus a converter stand-in
// assumes scan_sel_pkg compiled first and the checker bound to the design
`timescale 1ns/100ps
module tb_auto_scan_channel_select
    import scan_sel_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        scan_tick = 1'b0;
    logic        conv_done = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] conv_data = 16'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, period_restart, conv_valid, result_valid;
    conv_req_t   conv_req;
    result_t     result;
    conv_req_t   got_q[$], exp_q[$];
    int          errors = 0, n_checks = 0, n_res = 0, n_req = 0, dly = 0;

    auto_scan_channel_select i_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .scan_tick(scan_tick), .period_restart(period_restart), .conv_valid(conv_valid),
        .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data),
        .result_valid(result_valid), .result(result)
    );

    always #12.5 hclk = ~hclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // converter stand-in; data idles toggling, alternates quick and slow answers
    always @(posedge hclk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (dly == 1) begin
            conv_done <= 1'b1;
            conv_data <= 16'h0100 + 16'(got_q[$].channel);
        end
        if (dly != 0) dly <= dly - 1;
        if (conv_valid) begin
            got_q.push_back(conv_req);
            dly <= n_req[0] ? 6 : 2;
            n_req++;
        end
        if (result_valid) begin
            n_res++;
            chk(32'(result.data), 32'h100 + 32'(result.channel), "result");
        end
    end

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    function automatic void e(logic [4:0] c, timing_sel_t t, logic [7:0] p, int n);
        repeat (n) exp_q.push_back({c, t, p});
    endfunction

    // a scan is started by a period write or by a timer tick
    task automatic scan(input logic [31:0] chan, input logic [7:0] os, input int nres,
                        input logic tick);
        got_q.delete();
        n_res = 0;
        bus(1'b1, REG_IDX_CHAN, chan);
        bus(1'b1, REG_IDX_OSMPL, os);
        if (tick) begin
            scan_tick <= 1'b1;
            @(posedge hclk);
            scan_tick <= 1'b0;
        end else begin
            bus(1'b1, REG_IDX_PERIOD, 32'h1);
        end
        for (int i = 0; i < 3000 && got_q.size() < exp_q.size(); i++) @(posedge hclk);
        repeat (20) @(posedge hclk);
        chk(got_q.size(), exp_q.size(), "request count");
        foreach (exp_q[i]) chk(32'(got_q[i]), 32'(exp_q[i]), "request");
        chk(n_res, nres, "result count");
        exp_q.delete();
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, REG_IDX_CHAN, 32'h0);
        chk(rd, CHAN_RESET, "chan reset");
        bus(1'b1, REG_IDX_CHAN, 32'hFFFF_FFFF);
        bus(1'b0, REG_IDX_CHAN, 32'h0);
        chk(rd, 32'hFFFF_FF84, "chan reserved");
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0, "unmapped");
        chk(32'(hresp), 32'h0, "okay response");
        bus(1'b1, REG_IDX_SETTLE, 32'h0000_5A3C);
        e(5'h00, TM_CELL_SETTLE, 8'h3C, 1);
        e(5'h00, TM_ANALOG_AVG, 8'h03, 1);
        e(5'h10, TM_AUX_SETTLE, 8'h5A, 1);
        e(5'h10, TM_DIGITAL_AVG, 8'h00, 1);
        e(CH_DTEMP, TM_DIGITAL_AVG, 8'h00, 2);
        e(CH_REF, TM_ANALOG_AVG, 8'h03, 2);
        e(CH_REF_GND, TM_ANALOG_AVG, 8'h03, 2);
        scan(32'h0001_0184, 8'h61, 5, 1'b0);
        for (int k = 0; k < 2; k++) begin
            for (int p = 0; p < 2; p++) begin
                e(5'h00, TM_CELL_SETTLE, 8'h3C, 1);
                e(5'h01, TM_CELL_SETTLE, 8'h3C, 1);
            end
            for (int p = 0; p < 2; p++) begin
                e(5'h10, TM_AUX_SETTLE, 8'h5A, 1);
                e(5'h11, TM_AUX_SETTLE, 8'h5A, 1);
            end
            e(CH_DTEMP, TM_DIGITAL_AVG, 8'h03, 2);
            scan(32'h0003_0380, 8'hF9, 5, k[0]);
        end
        bus(1'b0, REG_IDX_OSMPL, 32'h0);
        chk(rd, 32'h0000_00F9, "osmpl readback");
        bus(1'b1, REG_IDX_PERIOD, 32'h0);
        got_q.delete();
        scan_tick <= 1'b1;
        @(posedge hclk);
        scan_tick <= 1'b0;
        repeat (50) @(posedge hclk);
        chk(got_q.size(), 0, "scan while stopped");
        close_out();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        close_out();
    end
endmodule // tb_auto_scan_channel_select

// file: verilog/auto_scan_channel_select.sv
// automatic scan channel selector: registers on AHB-Lite, scan sequencer,
// conversion requests to the converter and averaged results back out
// assumes the converter answers each request with one conv_done pulse and the
// scan period timer outside raises scan_tick once per period
//
// Operation
// - scan converts each cell whose mask bit is set; bit 0 is cell 1
// - scan converts each auxiliary input whose mask bit is set; bit 0 is aux 0
// - digital die temperature joins the scan only when its select bit is 1
// - reserved channel-select bits read zero; software writes them as zero
// - reference check adds reference voltage and reference ground to the sequence
// - reference voltage is sampled first, then its ground
// - averaging order bit affects only cell and auxiliary averaging
// - same-channel mode takes all oversamples of a channel before moving on
// - same-channel: a cell or aux input's first sample uses settling period, later ones averaging period
// - cycling mode samples each cell or aux input once per pass, repeating passes
// - cycling mode finishes cells before aux, aux before everything else
// - cycling mode uses cell settling for cells, aux settling for aux
// - analog-side period times reference voltage and reference ground
// - with order bit 0, analog-side period also times cell averaging
// - period code 0 stops scanning; any period write restarts the timer, a nonzero code also the scan
// - codes 0..5 give 1..32 samples; results convergent-rounded to 16 bits
// - digital-side period times digital temperature, and aux averaging when order is 0
`timescale 1ns/100ps
module auto_scan_channel_select
    import scan_sel_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scan_tick,
    output logic             period_restart,
    output logic             conv_valid,
    output conv_req_t        conv_req,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data,
    output logic             result_valid,
    output result_t          result
);

    typedef struct packed {
        logic              wr_pend;
        logic [7:0]        wr_idx;
        logic [31:0]       rdata;
        logic              ready;
        logic [3:0]        period;
        logic [31:0]       chan;
        logic [7:0]        osmpl;
        logic [15:0]       settle;
        logic              start_pend;
        logic              restart;
        scan_state_t       state;
        logic [NUM_CH-1:0] snap_mask;
        logic              snap_order;
        logic [2:0]        snap_ovs;
        logic [1:0]        snap_hper;
        logic [1:0]        snap_gper;
        logic [15:0]       snap_settle;
        logic [4:0]        ch;
        logic [4:0]        idx;
        logic              cur_first;
        logic              cur_last;
        logic              req_valid;
        conv_req_t         req;
        logic [15:0]       scans_done;
    } scan_st_t;

    scan_st_t st_ff;
    scan_st_t nxt_st;

    // lowest selected channel in [from, hi], or none
    function automatic logic [4:0] next_sel(input logic [NUM_CH-1:0] m,
                                            input logic [4:0] from,
                                            input logic [4:0] hi);
        logic [4:0] r;
        r = CH_NONE;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (5'(i) >= from && 5'(i) <= hi && m[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] group_lo(input logic [4:0] c);
        return (c <= CH_CELL_LAST) ? CH_CELL_FIRST :
               (c <= CH_AUX_LAST)  ? CH_AUX_FIRST  : CH_DTEMP;
    endfunction

    function automatic logic [4:0] group_hi(input logic [4:0] c);
        return (c <= CH_CELL_LAST) ? CH_CELL_LAST :
               (c <= CH_AUX_LAST)  ? CH_AUX_LAST  : CH_REF_GND;
    endfunction

    // conversion timing for one sample
    function automatic conv_req_t make_req(input logic [4:0] c,
                                           input logic first,
                                           input logic order,
                                           input logic [1:0] hper,
                                           input logic [1:0] gper,
                                           input logic [15:0] settle);
        conv_req_t r;
        r.channel = c;
        if (c <= CH_CELL_LAST) begin
            if (order || first) begin
                r.timing      = TM_CELL_SETTLE;
                r.period_code = settle[7:0];
            end else begin
                r.timing      = TM_ANALOG_AVG;
                r.period_code = {6'h0, hper};
            end
        end else if (c <= CH_AUX_LAST) begin
            if (order || first) begin
                r.timing      = TM_AUX_SETTLE;
                r.period_code = settle[SETTLE_AUX_LSB +: 8];
            end else begin
                r.timing      = TM_DIGITAL_AVG;
                r.period_code = {6'h0, gper};
            end
        end else if (c == CH_DTEMP) begin
            r.timing      = TM_DIGITAL_AVG;
            r.period_code = {6'h0, gper};
        end else begin
            r.timing      = TM_ANALOG_AVG;
            r.period_code = {6'h0, hper};
        end
        return r;
    endfunction

    logic       addr_ok;
    logic [7:0] addr_idx;
    logic [4:0] last_idx;

    assign addr_ok  = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    assign addr_idx = haddr[9:2];
    assign last_idx = 5'((6'h1 << st_ff.snap_ovs) - 6'h1);

    always_comb begin
        logic       cyc;
        logic [4:0] nx;
        logic [2:0] ovs;
        cyc    = 1'b0;
        nx     = CH_NONE;
        ovs    = '0;
        nxt_st = st_ff;
        nxt_st.restart   = 1'b0;
        nxt_st.req_valid = 1'b0;
        nxt_st.ready     = 1'b1;

        // bus data phase of a write
        if (st_ff.wr_pend) begin
            nxt_st.wr_pend = 1'b0;
            case (st_ff.wr_idx)
                REG_IDX_PERIOD: begin
                    nxt_st.period  = hwdata[3:0];
                    nxt_st.restart = 1'b1;
                    if (hwdata[3:0] != 4'h0) begin
                        nxt_st.start_pend = 1'b1;
                    end
                end
                REG_IDX_CHAN:   nxt_st.chan   = hwdata & CHAN_WR_MASK;
                REG_IDX_OSMPL:  nxt_st.osmpl  = hwdata[7:0];
                REG_IDX_SETTLE: nxt_st.settle = hwdata[15:0];
                default: ;
            endcase
        end

        // bus address phase
        if (hsel && htrans[1] && hready) begin
            nxt_st.wr_pend = hwrite && addr_ok;
            nxt_st.wr_idx  = addr_idx;
            nxt_st.rdata   = 32'h0;
            if (!hwrite && addr_ok) begin
                case (addr_idx)
                    REG_IDX_PERIOD: nxt_st.rdata = {28'h0, nxt_st.period};
                    REG_IDX_CHAN:   nxt_st.rdata = nxt_st.chan;
                    REG_IDX_OSMPL:  nxt_st.rdata = {24'h0, nxt_st.osmpl};
                    REG_IDX_SETTLE: nxt_st.rdata = {16'h0, nxt_st.settle};
                    REG_IDX_STATUS: nxt_st.rdata = {st_ff.scans_done, 3'h0,
                                                    st_ff.ch, 4'h0, st_ff.state};
                    default:        nxt_st.rdata = 32'h0;
                endcase
            end
        end

        if (scan_tick) begin
            nxt_st.start_pend = 1'b1;
        end

        case (st_ff.state)
            ST_IDLE: begin
                if (st_ff.start_pend && st_ff.period != 4'h0) begin
                    // settings are frozen here so writes touch only the next scan
                    ovs = (st_ff.osmpl[2:0] > OVS_MAX_CODE) ? OVS_MAX_CODE
                                                            : st_ff.osmpl[2:0];
                    nxt_st.snap_mask   = {st_ff.chan[CHAN_REF_BIT],
                                          st_ff.chan[CHAN_REF_BIT],
                                          st_ff.chan[CHAN_DTEMP_BIT],
                                          st_ff.chan[CHAN_AUX_LSB +: 8],
                                          st_ff.chan[CHAN_CELL_LSB +: 16]};
                    nxt_st.snap_order  = st_ff.osmpl[OSMPL_ORDER_BIT];
                    nxt_st.snap_ovs    = ovs;
                    nxt_st.snap_hper   = st_ff.osmpl[OSMPL_HPER_LSB +: 2];
                    nxt_st.snap_gper   = st_ff.osmpl[OSMPL_GPER_LSB +: 2];
                    nxt_st.snap_settle = st_ff.settle;
                    // a tick or a nonzero period write landing now stays pending
                    nxt_st.start_pend  = scan_tick ||
                                         (st_ff.wr_pend && st_ff.wr_idx == REG_IDX_PERIOD
                                          && hwdata[3:0] != 4'h0);
                    nxt_st.idx         = 5'h0;
                    nxt_st.ch = next_sel(nxt_st.snap_mask, CH_CELL_FIRST, CH_REF_GND);
                    if (nxt_st.ch == CH_NONE) begin
                        nxt_st.scans_done = st_ff.scans_done + 16'h1;
                    end else begin
                        nxt_st.state = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                nxt_st.req_valid = 1'b1;
                nxt_st.cur_first = (st_ff.idx == 5'h0);
                nxt_st.cur_last  = (st_ff.idx == last_idx);
                nxt_st.req = make_req(st_ff.ch, st_ff.idx == 5'h0, st_ff.snap_order,
                                      st_ff.snap_hper, st_ff.snap_gper,
                                      st_ff.snap_settle);
                nxt_st.state = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done) begin
                    nxt_st.state = ST_ADVANCE;
                end
            end
            ST_ADVANCE: begin
                cyc = st_ff.snap_order && (st_ff.ch <= CH_AUX_LAST);
                if (!cyc) begin
                    if (st_ff.idx != last_idx) begin
                        nxt_st.idx = st_ff.idx + 5'h1;
                        nx         = st_ff.ch;
                    end else begin
                        nxt_st.idx = 5'h0;
                        nx = next_sel(st_ff.snap_mask, st_ff.ch + 5'h1, CH_REF_GND);
                    end
                end else begin
                    nx = next_sel(st_ff.snap_mask, st_ff.ch + 5'h1,
                                  group_hi(st_ff.ch));
                    if (nx == CH_NONE) begin
                        if (st_ff.idx != last_idx) begin
                            nxt_st.idx = st_ff.idx + 5'h1;
                            nx = next_sel(st_ff.snap_mask, group_lo(st_ff.ch),
                                          group_hi(st_ff.ch));
                        end else begin
                            nxt_st.idx = 5'h0;
                            nx = next_sel(st_ff.snap_mask,
                                          group_hi(st_ff.ch) + 5'h1,
                                          CH_REF_GND);
                        end
                    end
                end
                nxt_st.ch = nx;
                if (nx == CH_NONE) begin
                    nxt_st.scans_done = st_ff.scans_done + 16'h1;
                    nxt_st.state      = ST_IDLE;
                end else begin
                    nxt_st.state = ST_ISSUE;
                end
            end
            default: nxt_st.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff        <= '0;
            st_ff.ready  <= 1'b1;
            st_ff.period <= PERIOD_RESET;
            st_ff.chan   <= CHAN_RESET;
            st_ff.osmpl  <= OSMPL_RESET;
            st_ff.settle <= SETTLE_RESET;
            st_ff.state  <= ST_IDLE;
            st_ff.ch     <= CH_NONE;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    scan_average_round u_avg (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ce         (ce),
        .in_valid   (conv_done && st_ff.state == ST_WAIT),
        .in_ch      (st_ff.ch),
        .in_first   (st_ff.cur_first),
        .in_last    (st_ff.cur_last),
        .in_data    (conv_data),
        .shift      (st_ff.snap_ovs),
        .out_valid  (result_valid),
        .out_result (result)
    );

    assign hrdata         = st_ff.rdata;
    assign hreadyout      = st_ff.ready;
    assign hresp          = 1'b0;
    assign period_restart = st_ff.restart;
    assign conv_valid     = st_ff.req_valid;
    assign conv_req       = st_ff.req;

endmodule // auto_scan_channel_select

// file: verilog/scan_average_round.sv
// per-channel oversampling accumulators with convergent rounding to 16 bits
// assumes samples arrive one per cycle at most, flagged first and last
`timescale 1ns/100ps
module scan_average_round
    import scan_sel_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        in_valid,
    input  wire logic [4:0]  in_ch,
    input  wire logic        in_first,
    input  wire logic        in_last,
    input  wire logic [15:0] in_data,
    input  wire logic [2:0]  shift,
    output logic             out_valid,
    output result_t          out_result
);

    typedef struct packed {
        logic [NUM_CH-1:0][ACC_W-1:0] acc;
        logic                         valid;
        result_t                      res;
    } avg_state_t;

    avg_state_t st_ff;
    avg_state_t nxt_st;

    // round half to even, saturating at full scale
    function automatic logic [15:0] conv_round(input logic [ACC_W-1:0] s,
                                               input logic [2:0] k);
        logic [ACC_W-1:0] q;
        logic [ACC_W-1:0] rem;
        logic [ACC_W-1:0] half;
        logic [ACC_W:0]   r;
        q    = s >> k;
        rem  = s & ((21'h1 << k) - 21'h1);
        half = (k == 3'h0) ? 21'h0 : (21'h1 << 3'(k - 3'h1));
        r    = {1'b0, q};
        if (k != 3'h0 && (rem > half || (rem == half && q[0]))) begin
            r = r + 22'h1;
        end
        return (r > 22'h00FFFF) ? 16'hFFFF : r[15:0];
    endfunction

    always_comb begin
        logic [ACC_W-1:0] sum;
        sum    = '0;
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        if (in_valid && in_ch < 5'(NUM_CH)) begin
            sum = (in_first ? 21'h0 : st_ff.acc[in_ch]) + {5'h0, in_data};
            nxt_st.acc[in_ch] = sum;
            if (in_last) begin
                nxt_st.valid       = 1'b1;
                nxt_st.res.channel = in_ch;
                nxt_st.res.data    = conv_round(sum, shift);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign out_valid  = st_ff.valid;
    assign out_result = st_ff.res;

endmodule // scan_average_round

// file: verilog/scan_sel_pkg.sv
// constants and carrier types of the automatic scan channel selector
// assumes one 40 MHz bus clock; the converter and the period timer sit outside
package scan_sel_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  REG_IDX_PERIOD   = 8'h32;
    localparam logic [7:0]  REG_IDX_CHAN     = 8'h33;
    localparam logic [7:0]  REG_IDX_OSMPL    = 8'h37;
    localparam logic [7:0]  REG_IDX_SETTLE   = 8'h38;
    localparam logic [7:0]  REG_IDX_STATUS   = 8'h39;

    // values after reset
    localparam logic [3:0]  PERIOD_RESET     = 4'h0;
    localparam logic [31:0] CHAN_RESET       = 32'h0000_0000;
    localparam logic [7:0]  OSMPL_RESET      = 8'h00;
    localparam logic [15:0] SETTLE_RESET     = 16'h0000;

    // writable bits of the channel select register
    localparam logic [31:0] CHAN_WR_MASK     = 32'hFFFF_FF84;

    // field positions
    localparam int          CHAN_CELL_LSB    = 16;
    localparam int          CHAN_AUX_LSB     = 8;
    localparam int          CHAN_DTEMP_BIT   = 7;
    localparam int          CHAN_REF_BIT     = 2;
    localparam int          OSMPL_ORDER_BIT  = 7;
    localparam int          OSMPL_HPER_LSB   = 5;
    localparam int          OSMPL_GPER_LSB   = 3;
    localparam int          SETTLE_AUX_LSB   = 8;

    // channel numbering of the scan sequence
    localparam logic [4:0]  CH_CELL_FIRST    = 5'h00;
    localparam logic [4:0]  CH_CELL_LAST     = 5'h0F;
    localparam logic [4:0]  CH_AUX_FIRST     = 5'h10;
    localparam logic [4:0]  CH_AUX_LAST      = 5'h17;
    localparam logic [4:0]  CH_DTEMP         = 5'h18;
    localparam logic [4:0]  CH_REF           = 5'h19;
    localparam logic [4:0]  CH_REF_GND       = 5'h1A;
    localparam logic [4:0]  CH_NONE          = 5'h1F;
    localparam int          NUM_CH           = 27;

    localparam logic [2:0]  OVS_MAX_CODE     = 3'h5;
    localparam int          ACC_W            = 21;

    typedef enum logic [1:0] {
        TM_CELL_SETTLE  = 2'h0,
        TM_AUX_SETTLE   = 2'h1,
        TM_ANALOG_AVG   = 2'h2,
        TM_DIGITAL_AVG  = 2'h3
    } timing_sel_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_ISSUE   = 4'b0010,
        ST_WAIT    = 4'b0100,
        ST_ADVANCE = 4'b1000
    } scan_state_t;

    typedef struct packed {
        logic [4:0]  channel;
        timing_sel_t timing;
        logic [7:0]  period_code;
    } conv_req_t;

    typedef struct packed {
        logic [4:0]  channel;
        logic [15:0] data;
    } result_t;

endpackage
